/* inc/csfoa_pkg.sv */
// package: constants for the core status flags and operand addressing block
package csfoa_pkg;
  // register offsets on the plain register port
  localparam logic [11:0] STATUS_OFS   = 12'hFD8;
  localparam logic [11:0] BANK_OFS     = 12'hFE0;
  localparam logic [11:0] PTR2_OFS     = 12'hFD9;
  localparam logic [11:0] CTRL_OFS     = 12'hFC0;
  localparam logic [11:0] EA_OFS       = 12'hFC1;
  // status field positions
  localparam int TIMEOUT_BIT = 6;
  localparam int PWRDN_BIT   = 5;
  localparam int N_BIT       = 4;
  localparam int OVF_BIT     = 3;
  localparam int Z_BIT       = 2;
  localparam int DCARRY_BIT  = 1;
  localparam int C_BIT       = 0;
  // reset values
  localparam logic [7:0]  STATUS_RST = 8'h60;
  localparam logic [3:0]  BANK_RST   = 4'h0;
  localparam logic [11:0] PTR2_RST   = 12'h000;
  // operand decode
  localparam logic [5:0]  ADD_ACC_OPC   = 6'h09;
  localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
  localparam logic [3:0]  ACCESS_BANK   = 4'hF;
  // addressing modes
  typedef enum logic [1:0] {
    CSFOA_MODE_NONE,
    CSFOA_MODE_FORCED,
    CSFOA_MODE_INDEXED,
    CSFOA_MODE_LONG
  } csfoa_mode_e;
endpackage

/* inc/csfoa_addr_if.sv */
// interface: operand address request and result between decoder and core
`timescale 1ns/1ps
`default_nettype none
interface csfoa_addr_if;
  logic [15:0] opcode;
  logic        ext_en;
  logic [3:0]  bank;
  logic [11:0] ptr2;
  logic        is_add;
  logic [1:0]  mode;
  logic [11:0] addr;
  modport core (output opcode, output ext_en, output bank, output ptr2,
                input is_add, input mode, input addr);
  modport dec  (input opcode, input ext_en, input bank, input ptr2,
                output is_add, output mode, output addr);
endinterface
`default_nettype wire

/* rtl/csfoa_addr_dec.sv */
// module: combinational file-operand address resolver
`timescale 1ns/1ps
`default_nettype none
module csfoa_addr_dec (
  csfoa_addr_if.dec ai
);
  logic       acc_bit;
  logic [7:0] fld;

  assign acc_bit = ai.opcode[8];
  assign fld     = ai.opcode[7:0];
  // add-accumulator-to-file pattern
  assign ai.is_add = (ai.opcode[15:10] == csfoa_pkg::ADD_ACC_OPC);

  always_comb begin
    if (acc_bit) begin
      ai.mode = csfoa_pkg::CSFOA_MODE_LONG;
      ai.addr = {ai.bank, fld};
    end else if (fld >= csfoa_pkg::ACCESS_SPLIT || !ai.ext_en) begin
      // low part maps to bank 0 when extended set is off
      ai.mode = csfoa_pkg::CSFOA_MODE_FORCED;
      ai.addr = (fld >= csfoa_pkg::ACCESS_SPLIT) ? {csfoa_pkg::ACCESS_BANK, fld}
                                                 : {4'h0, fld};
    end else begin
      ai.mode = csfoa_pkg::CSFOA_MODE_INDEXED;
      ai.addr = ai.ptr2 + {4'h0, fld};
    end
  end
endmodule
`default_nettype wire

/* rtl/csfoa_core.sv */
// module: core status flags register and operand address resolution
//
// How it works
// - watchdog expiry clears timeout; clear/sleep/power-up set
// - powerdown set by power-up/clear, cleared by sleep
// - por/brownout forces timeout and powerdown to one
// - negative flag copies result msb
// - overflow set when signed sign flips wrongly
// - por/brownout clears negative, overflow, zero flags
// - decode add pattern 0010 01da ffff ffff
// - access bit 0, f>=60h maps bank 15
// - indexed mode adds f to pointer two
// - access bit 1 uses bank select
`timescale 1ns/1ps
`default_nettype none
module csfoa_core (
  // clock, reset, enable
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  // reset causes (same-clock logic)
  input  wire logic        por_i,
  input  wire logic        brownout_reset_i,
  // core events (one-cycle pulses)
  input  wire logic        clear_watchdog_instr_i,
  input  wire logic        sleep_instr_i,
  input  wire logic        watchdog_timer_expired_i,
  // alu result update
  input  wire logic        alu_valid_i,
  input  wire logic [7:0]  alu_a_i,
  input  wire logic [7:0]  alu_b_i,
  input  wire logic        alu_sub_i,
  // instruction operand decode
  input  wire logic        instr_valid_i,
  input  wire logic [15:0] instr_i,
  // register port
  input  wire logic [11:0] reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  // results
  output logic      [7:0]  status_o,
  output logic      [11:0] operand_addr_o,
  output logic      [1:0]  operand_mode_o,
  output logic             operand_valid_o,
  output logic             operand_is_add_o
);
  logic        tmo_q;
  logic        pdn_q;
  logic [4:0]  arith_q;
  logic [7:0]  status_w;
  logic [3:0]  bank_q;
  logic [11:0] ptr2_q;
  logic        ext_en_q;
  logic [7:0]  rdata_q;
  logic [11:0] addr_q;
  logic [1:0]  mode_q;
  logic        valid_q;
  logic        is_add_q;
  logic        cold;
  logic [8:0]  sum;
  logic [7:0]  opb;
  logic [4:0]  nib;
  logic        ovf;

  csfoa_addr_if ai ();

  assign ai.opcode = instr_i;
  assign ai.ext_en = ext_en_q;
  assign ai.bank   = bank_q;
  assign ai.ptr2   = ptr2_q;

  csfoa_addr_dec u_dec (
    .ai (ai)
  );

  assign cold = por_i | brownout_reset_i;

  // subtract as add of complement plus one
  assign opb = alu_sub_i ? ~alu_b_i : alu_b_i;
  assign sum = {1'b0, alu_a_i} + {1'b0, opb} + {8'h00, alu_sub_i};
  assign nib = {1'b0, alu_a_i[3:0]} + {1'b0, opb[3:0]} + {4'h0, alu_sub_i};
  // operands share sign, result sign differs
  assign ovf = (alu_a_i[7] == opb[7]) && (sum[7] != alu_a_i[7]);

  // watchdog timeout and powerdown flags
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      tmo_q <= csfoa_pkg::STATUS_RST[csfoa_pkg::TIMEOUT_BIT];
      pdn_q <= csfoa_pkg::STATUS_RST[csfoa_pkg::PWRDN_BIT];
    end else if (ce_i) begin
      if (cold) begin
        tmo_q <= 1'b1;
        pdn_q <= 1'b1;
      end else begin
        if (clear_watchdog_instr_i || sleep_instr_i) begin
          tmo_q <= 1'b1;
        end else if (watchdog_timer_expired_i) begin
          tmo_q <= 1'b0;
        end
        if (clear_watchdog_instr_i) begin
          pdn_q <= 1'b1;
        end else if (sleep_instr_i) begin
          pdn_q <= 1'b0;
        end
      end
    end
  end

  // arithmetic flags, writable by software
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      arith_q <= csfoa_pkg::STATUS_RST[4:0];
    end else if (ce_i) begin
      if (cold) begin
        arith_q[csfoa_pkg::N_BIT]   <= 1'b0;
        arith_q[csfoa_pkg::OVF_BIT] <= 1'b0;
        arith_q[csfoa_pkg::Z_BIT]   <= 1'b0;
      end else if (alu_valid_i) begin
        arith_q[csfoa_pkg::N_BIT]      <= sum[7];
        arith_q[csfoa_pkg::OVF_BIT]    <= ovf;
        arith_q[csfoa_pkg::Z_BIT]      <= (sum[7:0] == 8'h00);
        arith_q[csfoa_pkg::DCARRY_BIT] <= nib[4];
        arith_q[csfoa_pkg::C_BIT]      <= sum[8];
      end else if (reg_wr_i && reg_addr_i == csfoa_pkg::STATUS_OFS) begin
        arith_q <= reg_wdata_i[4:0];
      end
    end
  end

  assign status_w = {1'b0, tmo_q, pdn_q, arith_q};

  // bank select, pointer two, extended-set enable
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      bank_q   <= csfoa_pkg::BANK_RST;
      ptr2_q   <= csfoa_pkg::PTR2_RST;
      ext_en_q <= 1'b0;
    end else if (ce_i && reg_wr_i) begin
      case (reg_addr_i)
        csfoa_pkg::BANK_OFS: bank_q   <= reg_wdata_i[3:0];
        csfoa_pkg::PTR2_OFS: ptr2_q   <= {ptr2_q[11:8], reg_wdata_i};
        csfoa_pkg::CTRL_OFS: begin
          ext_en_q         <= reg_wdata_i[0];
          ptr2_q[11:8]     <= reg_wdata_i[7:4];
        end
        default: ;
      endcase
    end
  end

  // registered operand address
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      addr_q   <= 12'h000;
      mode_q   <= 2'h0;
      valid_q  <= 1'b0;
      is_add_q <= 1'b0;
    end else if (ce_i) begin
      valid_q <= instr_valid_i;
      if (instr_valid_i) begin
        addr_q   <= ai.addr;
        mode_q   <= ai.mode;
        is_add_q <= ai.is_add;
      end
    end
  end

  // read port, data one cycle after strobe
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      if (reg_rd_i) begin
        case (reg_addr_i)
          csfoa_pkg::STATUS_OFS: rdata_q <= status_w;
          csfoa_pkg::BANK_OFS:   rdata_q <= {4'h0, bank_q};
          csfoa_pkg::PTR2_OFS:   rdata_q <= ptr2_q[7:0];
          csfoa_pkg::CTRL_OFS:   rdata_q <= {ptr2_q[11:8], 3'h0, ext_en_q};
          csfoa_pkg::EA_OFS:     rdata_q <= addr_q[7:0];
          default:               rdata_q <= 8'h00;
        endcase
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign reg_rdata_o      = rdata_q;
  assign status_o         = status_w;
  assign operand_addr_o   = addr_q;
  assign operand_mode_o   = mode_q;
  assign operand_valid_o  = valid_q;
  assign operand_is_add_o = is_add_q;
endmodule
`default_nettype wire

/* test/csfoa_core_checker.sv */
// checker: status flag and operand address assertions
`timescale 1ns/1ps
`default_nettype none
module csfoa_core_checker (
  // clock, reset, enable
  input wire logic        clk_sys_i,
  input wire logic        nrst_i,
  input wire logic        ce_i,
  // events
  input wire logic        por_i,
  input wire logic        brownout_reset_i,
  input wire logic        clear_watchdog_instr_i,
  input wire logic        sleep_instr_i,
  input wire logic        watchdog_timer_expired_i,
  // alu and instruction
  input wire logic        alu_valid_i,
  input wire logic [7:0]  alu_a_i,
  input wire logic [7:0]  alu_b_i,
  input wire logic        alu_sub_i,
  input wire logic        instr_valid_i,
  input wire logic [15:0] instr_i,
  // results
  input wire logic [7:0]  status_o,
  input wire logic [11:0] operand_addr_o,
  input wire logic [1:0]  operand_mode_o,
  input wire logic        operand_valid_o,
  input wire logic        operand_is_add_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  logic [7:0] bb;
  logic [7:0] res;
  logic [1:0] nv;
  logic       hw;
  logic       add;
  assign bb  = alu_sub_i ? ~alu_b_i : alu_b_i;
  assign res = alu_a_i + bb + {7'h00, alu_sub_i};
  assign nv  = {res[7], (alu_a_i[7] == bb[7]) & (res[7] != alu_a_i[7])};
  assign hw  = ce_i & ~por_i & ~brownout_reset_i;
  assign add = ce_i & instr_valid_i & (instr_i[15:10] == 6'h09);
  AST_EXPIRY: assert property (hw & watchdog_timer_expired_i & ~clear_watchdog_instr_i
    & ~sleep_instr_i |=> !status_o[6]) else $error("timeout flag not cleared");
  AST_CLEAR_WD: assert property (hw & clear_watchdog_instr_i
    |=> status_o[6:5] == 2'h3) else $error("clear watchdog flags wrong");
  AST_SLEEP: assert property (hw & sleep_instr_i & ~clear_watchdog_instr_i
    |=> status_o[6:5] == 2'h2) else $error("sleep flags wrong");
  AST_POWER: assert property (ce_i & (por_i | brownout_reset_i)
    |=> status_o[6:2] == 5'h18) else $error("power reset flags wrong");
  AST_NEG_OVF: assert property (hw & alu_valid_i
    |=> status_o[4:3] == $past(nv)) else $error("negative or overflow flag wrong");
  AST_DECODE: assert property (ce_i & instr_valid_i |=> operand_valid_o
    && operand_is_add_o == $past(add)) else $error("decode wrong");
  AST_FORCED: assert property (add & !instr_i[8] & instr_i[7:0] >= 8'h60
    |=> operand_mode_o == 2'h1 && operand_addr_o == {4'hF, $past(instr_i[7:0])})
    else $error("forced address wrong");
  AST_LONG: assert property (add & instr_i[8] |=> operand_mode_o == 2'h3
    && operand_addr_o[7:0] == $past(instr_i[7:0])) else $error("long address wrong");
endmodule
bind csfoa_core csfoa_core_checker i_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce_i),
  .por_i(por_i), .brownout_reset_i(brownout_reset_i),
  .clear_watchdog_instr_i(clear_watchdog_instr_i), .sleep_instr_i(sleep_instr_i),
  .watchdog_timer_expired_i(watchdog_timer_expired_i), .alu_valid_i(alu_valid_i),
  .alu_a_i(alu_a_i), .alu_b_i(alu_b_i), .alu_sub_i(alu_sub_i), .instr_valid_i(instr_valid_i),
  .instr_i(instr_i), .status_o(status_o), .operand_addr_o(operand_addr_o),
  .operand_mode_o(operand_mode_o), .operand_valid_o(operand_valid_o),
  .operand_is_add_o(operand_is_add_o));
`default_nettype wire

/* test/test_core_status_flags_and_operand_addressing.sv */
// testbench: status flags and operand addressing
`timescale 1ns/1ps
`default_nettype none
module test_core_status_flags_and_operand_addressing;
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, alv = 1'b0, als = 1'b0, iv = 1'b0, wr = 1'b0, rd = 1'b0;
  logic ce = 1'b1;
  logic [4:0]  ev = 5'h00;  // por, brownout, clear watchdog, sleep, expiry
  logic [7:0]  aa = 8'h00, ab = 8'h00, rw = 8'h00, rdat, st, d;
  logic [11:0] ra = 12'h000, oa;
  logic [15:0] ins = 16'h0000;
  logic [1:0]  om;
  logic        ov, oadd;
  logic [31:0] seed, r;
  int fails = 0, samples_checked = 0, cyc = 0;
  logic [4:0] evs [6] = '{5'h01, 5'h04, 5'h02, 5'h06, 5'h03, 5'h10};
  logic [7:0] exs [6] = '{8'h20, 8'h60, 8'h40, 8'h60, 8'h40, 8'h60};
  always #2 clk_sys_i = ~clk_sys_i;
  csfoa_core i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce), .por_i(ev[4]),
    .brownout_reset_i(ev[3]), .clear_watchdog_instr_i(ev[2]), .sleep_instr_i(ev[1]),
    .watchdog_timer_expired_i(ev[0]), .alu_valid_i(alv), .alu_a_i(aa), .alu_b_i(ab),
    .alu_sub_i(als), .instr_valid_i(iv), .instr_i(ins), .reg_addr_i(ra), .reg_wdata_i(rw),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .status_o(st), .operand_addr_o(oa),
    .operand_mode_o(om), .operand_valid_o(ov), .operand_is_add_o(oadd));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [2:0] nvz(input logic [7:0] a, b, input logic s);
    logic [7:0] x, y;
    x = s ? ~b : b;
    y = a + x + {7'h00, s};
    return {y[7], (a[7] == x[7]) & (y[7] != a[7]), y == 8'h00};
  endfunction
  function automatic logic [13:0] ea(input logic a, input logic [7:0] f, input logic x);
    if (a) return {2'h3, 4'h5, f};
    if (f >= 8'h60) return {2'h1, 4'hF, f};
    if (x) return {2'h2, 12'h1F0 + {4'h0, f}};
    return {2'h1, 4'h0, f};
  endfunction
  task automatic step();
    @(posedge clk_sys_i);
    {ev, alv, iv, wr, rd} <= 9'h000;
    #1;
  endtask
  task automatic wreg(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    {ra, rw, wr} <= {a, v, 1'b1};
    step();
  endtask
  task automatic rreg(input logic [11:0] a);
    @(posedge clk_sys_i);
    {ra, rd} <= {a, 1'b1};
    step();
    d = rdat;
  endtask
  initial begin
    seed = 32'h79BFD03F;
    repeat (10) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    #1 chk("status reset", {8'h00, st}, 16'h0060);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys_i);
      ev <= evs[i];
      step();
      chk("status event", {8'h00, st}, {8'h00, exs[i]});
    end
    @(posedge clk_sys_i);
    {ce, ev} <= {1'b0, 5'h01};
    step();
    chk("frozen", {8'h00, st}, 16'h0060);
    ce <= 1'b1;
    $display("events done");
    for (int i = 0; i < 40; i++) begin
      r = i == 0 ? 32'h0000017F : i == 1 ? 32'h00010180 : rnd();
      @(posedge clk_sys_i);
      {als, ab, aa, alv} <= {r[16:0], 1'b1};
      step();
      chk("alu flags", {13'h0000, st[4:2]}, {13'h0000, nvz(r[7:0], r[15:8], r[16])});
    end
    $display("alu done");
    wreg(12'hFD8, 8'h1F);
    rreg(12'hFD8);
    chk("status write", {8'h00, d}, 16'h007F);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys_i);
      ev <= i ? 5'h08 : 5'h02;
      step();
      chk("reset cause", {8'h00, st}, i ? 16'h0063 : 16'h005F);
    end
    rreg(12'h123);
    chk("unmapped", {8'h00, d}, 16'h0000);
    wreg(12'hFE0, 8'h05);
    wreg(12'hFD9, 8'hF0);
    rreg(12'hFE0);
    chk("bank read", {8'h00, d}, 16'h0005);
    rreg(12'hFD9);
    chk("pointer read", {8'h00, d}, 16'h00F0);
    @(posedge clk_sys_i);
    #1 chk("read idle", {8'h00, rdat}, 16'h0000);
    for (int x = 1; x >= 0; x--) begin
      wreg(12'hFC0, x ? 8'h11 : 8'h10);
      for (int i = 0; i < 40; i++) begin
        r = rnd();
        if (r[17]) r[15:10] = 6'h09;
        if (i < 2) r[15:0] = 16'h245F + 16'(i);
        @(posedge clk_sys_i);
        {ins, iv} <= {r[15:0], 1'b1};
        step();
        chk("is add", {15'h0000, oadd}, {15'h0000, r[15:10] == 6'h09});
        if (r[15:10] == 6'h09)
          chk("operand", {1'b0, ov, om, oa}, {2'h1, ea(r[8], r[7:0], x[0])});
      end
    end
    $display("operand done");
    end_sim();
  end
endmodule
`default_nettype wire
